//--- hw/xcfg_defs.svh
// constants for the exception mask and configuration register group
`ifndef XCFG_DEFS_SVH
`define XCFG_DEFS_SVH

// ----------------------------------------
// command framing bytes
// ----------------------------------------
`define FRAME_HEADER 8'hFF
`define FRAME_SIZE 8'h02
`define FRAME_ESCAPE 8'hFE
`define FRAME_ACK 8'h06

// ----------------------------------------
// volatile and non-volatile addresses
// ----------------------------------------
`define ADDR_ALERT_MASK 8'h6C
`define ADDR_ALERT_MASK_NV 8'h21
`define ADDR_TRAFFIC_HOLD 8'h6E
`define ADDR_TRAFFIC_HOLD_NV 8'h23
`define ADDR_GAIN_MODE 8'h6F
`define ADDR_GAIN_MODE_NV 8'h24
`define ADDR_LEGACY 8'h70
`define ADDR_LEGACY_NV 8'h25
`define ADDR_FAULT_CODE 8'h79

// ----------------------------------------
// reset values and legal limits
// ----------------------------------------
`define RST_ALERT_MASK 8'h00
`define RST_TRAFFIC_HOLD 8'h00
`define RST_GAIN_MODE 8'h00
`define RST_LEGACY 8'h00
`define GAIN_MODE_MAX 8'h03
`define SWITCH_MAX 8'h01
`define HOLD_ON 8'h01

// ----------------------------------------
// fault codes raised by this block
// ----------------------------------------
`define CODE_RF_OVERFLOW 8'h09
`define CODE_WRITE_FAILED 8'h13

// ----------------------------------------
// rf packet buffer geometry
// ----------------------------------------
`define RF_BUF_DEPTH 16
`define RF_PTR_W 5

`endif

//--- hw/xcfg_pkg.sv
// types for the exception mask and configuration register group
`include "xcfg_defs.svh"
package xcfg_pkg;

	// command parser states, gray coded along the frame
	typedef enum logic [2:0]
	{
		P_HDR = 3'b000,
		P_SIZE = 3'b001,
		P_KIND = 3'b011,
		P_RADDR = 3'b010,
		P_WVAL = 3'b111,
		P_RESP = 3'b110
	} parse_state_t;

	// whole state of the register group
	typedef struct packed
	{
		parse_state_t st;
		logic [7:0] addr;
		logic [23:0] resp;
		logic [1:0] resp_left;
		logic [7:0] alert_mask;
		logic [7:0] alert_mask_nv;
		logic [7:0] traffic_hold;
		logic [7:0] traffic_hold_nv;
		logic [7:0] gain_mode;
		logic [7:0] gain_mode_nv;
		logic [7:0] legacy;
		logic [7:0] legacy_nv;
		logic [7:0] fault_code;
		logic alert;
		logic cmd_s1;
		logic cmd_s2;
		logic cmd_s3;
		logic cmd_low;
		logic [`RF_BUF_DEPTH-1:0][7:0] mem;
		logic [`RF_PTR_W-1:0] wptr;
		logic [`RF_PTR_W-1:0] rptr;
		logic out_valid;
		logic [7:0] out_byte;
	} xcfg_state_t;

endpackage

//--- hw/exception_mask_config_regs.sv
// exception mask, traffic hold, gain mode and legacy registers behind the command stream
//
// Functional notes
// - mask register at 0x6C, copy at 0x21
// - on exception, AND mask with code
// - non-zero masked result raises alert line
// - zero result: no alert, code still recorded
// - reading fault code clears alert
// - mask 0x08 passes both overflow codes
// - mask 0x10 passes write failure only
// - mask 0x20 passes missing acknowledge only
// - mask 0x40 passes crc, sequence, frame errors
// - mask 0xFF passes every code
// - hold 0x01 buffers rf while command low
// - held traffic beyond buffer capacity overflows
// - command high releases all buffered data
// - gain mode defaults automatic; 1..3 fixed
// - legacy register 0x01 enables, 0x00 disables
`include "xcfg_defs.svh"
module exception_mask_config_regs
	import xcfg_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// command bytes from the uart receiver
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	// response bytes to the uart transmitter
	output logic tx_valid,
	output logic [7:0] tx_byte,
	input wire logic tx_ready,
	// command line pin, active low
	input wire logic cmd_n,
	// exception engine events
	input wire logic exc_valid,
	input wire logic [7:0] exc_code,
	// received rf data in and out
	input wire logic rf_valid,
	input wire logic [7:0] rf_byte,
	output logic rf_out_valid,
	output logic [7:0] rf_out_byte,
	input wire logic rf_out_ready,
	// alert line and radio settings
	output logic alert_line,
	output logic [7:0] gain_mode,
	output logic legacy_link_enable
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------

	// true for every address this group answers
	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a == `ADDR_ALERT_MASK) || (a == `ADDR_ALERT_MASK_NV)
			|| (a == `ADDR_TRAFFIC_HOLD) || (a == `ADDR_TRAFFIC_HOLD_NV)
			|| (a == `ADDR_GAIN_MODE) || (a == `ADDR_GAIN_MODE_NV)
			|| (a == `ADDR_LEGACY) || (a == `ADDR_LEGACY_NV)
			|| (a == `ADDR_FAULT_CODE);
	endfunction

	// legal value limit per address; fault code is read only
	function automatic logic wr_ok(input logic [7:0] a, input logic [7:0] v);
		wr_ok = 1'b1;
		if (!addr_known(a) || a == `ADDR_FAULT_CODE)
			wr_ok = 1'b0;
		else if (a == `ADDR_GAIN_MODE || a == `ADDR_GAIN_MODE_NV)
			wr_ok = (v <= `GAIN_MODE_MAX);
		else if (a == `ADDR_TRAFFIC_HOLD || a == `ADDR_TRAFFIC_HOLD_NV
			|| a == `ADDR_LEGACY || a == `ADDR_LEGACY_NV)
			wr_ok = (v <= `SWITCH_MAX);
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	xcfg_state_t q; // registered state
	xcfg_state_t d; // next state
	logic holding; // rf output stalled by the command line
	logic buf_full; // rf buffer has no room
	logic buf_empty; // rf buffer holds nothing
	logic ev_fire; // an exception is taken this cycle
	logic [7:0] ev_code; // code of that exception
	logic fault_read; // fault code read completes this cycle
	logic wr_fail; // a write frame was refused

	assign holding = (q.traffic_hold == `HOLD_ON) && q.cmd_low;
	assign buf_full = (q.wptr[`RF_PTR_W-2:0] == q.rptr[`RF_PTR_W-2:0])
		&& (q.wptr[`RF_PTR_W-1] != q.rptr[`RF_PTR_W-1]);
	assign buf_empty = (q.wptr == q.rptr);
	assign wr_fail = (q.st == P_WVAL) && rx_valid && !wr_ok(q.addr, rx_byte);
	assign fault_read = (q.st == P_RADDR) && rx_valid && (rx_byte == `ADDR_FAULT_CODE);

	// one exception per cycle: buffer overflow first, then refused write, then engine
	always_comb
	begin
		ev_fire = 1'b1;
		ev_code = exc_code;
		if (rf_valid && buf_full)
			ev_code = `CODE_RF_OVERFLOW;
		else if (wr_fail)
			ev_code = `CODE_WRITE_FAILED;
		else
			ev_fire = exc_valid;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		d = q;

		// command pin synchroniser; level accepted once stages two and three agree
		d.cmd_s1 = cmd_n;
		d.cmd_s2 = q.cmd_s1;
		d.cmd_s3 = q.cmd_s2;
		if (q.cmd_s2 == q.cmd_s3)
			d.cmd_low = !q.cmd_s3;

		// command frame parser
		unique case (q.st)
			P_HDR:
			begin
				if (rx_valid && rx_byte == `FRAME_HEADER)
					d.st = P_SIZE;
			end
			P_SIZE:
			begin
				if (rx_valid)
					d.st = (rx_byte == `FRAME_SIZE) ? P_KIND : P_HDR;
			end
			P_KIND:
			begin
				// escape marks a read, anything else is a write address
				if (rx_valid && rx_byte == `FRAME_ESCAPE)
					d.st = P_RADDR;
				else if (rx_valid)
				begin
					d.addr = rx_byte;
					d.st = P_WVAL;
				end
			end
			P_RADDR:
			begin
				if (rx_valid)
				begin
					d.addr = rx_byte;
					d.resp[23:16] = `FRAME_ACK;
					d.resp[15:8] = rx_byte;
					unique case (rx_byte)
						`ADDR_ALERT_MASK: d.resp[7:0] = q.alert_mask;
						`ADDR_ALERT_MASK_NV: d.resp[7:0] = q.alert_mask_nv;
						`ADDR_TRAFFIC_HOLD: d.resp[7:0] = q.traffic_hold;
						`ADDR_TRAFFIC_HOLD_NV: d.resp[7:0] = q.traffic_hold_nv;
						`ADDR_GAIN_MODE: d.resp[7:0] = q.gain_mode;
						`ADDR_GAIN_MODE_NV: d.resp[7:0] = q.gain_mode_nv;
						`ADDR_LEGACY: d.resp[7:0] = q.legacy;
						`ADDR_LEGACY_NV: d.resp[7:0] = q.legacy_nv;
						`ADDR_FAULT_CODE: d.resp[7:0] = q.fault_code;
						// unmapped reads answer zero
						default: d.resp[7:0] = 8'h00;
					endcase
					d.resp_left = 2'd2;
					d.st = P_RESP;
				end
			end
			P_WVAL:
			begin
				// refused writes leave the register alone and raise a fault
				if (rx_valid && wr_ok(q.addr, rx_byte))
				begin
					unique case (q.addr)
						`ADDR_ALERT_MASK: d.alert_mask = rx_byte;
						`ADDR_ALERT_MASK_NV: d.alert_mask_nv = rx_byte;
						`ADDR_TRAFFIC_HOLD: d.traffic_hold = rx_byte;
						`ADDR_TRAFFIC_HOLD_NV: d.traffic_hold_nv = rx_byte;
						`ADDR_GAIN_MODE: d.gain_mode = rx_byte;
						`ADDR_GAIN_MODE_NV: d.gain_mode_nv = rx_byte;
						`ADDR_LEGACY: d.legacy = rx_byte;
						`ADDR_LEGACY_NV: d.legacy_nv = rx_byte;
						default: d.legacy = q.legacy;
					endcase
				end
				if (rx_valid)
					d.st = P_HDR;
			end
			P_RESP:
			begin
				// three bytes out, oldest in the top lane; rx is ignored meanwhile
				if (tx_ready)
				begin
					d.resp = {q.resp[15:0], 8'h00};
					d.resp_left = q.resp_left - 2'd1;
					if (q.resp_left == 2'd0)
						d.st = P_HDR;
				end
			end
			default: d.st = P_HDR;
		endcase

		// fault code and alert; a new exception beats the clearing read
		if (fault_read)
		begin
			d.alert = 1'b0;
			d.fault_code = 8'h00;
		end
		if (ev_fire)
		begin
			d.fault_code = ev_code;
			// fall out of the plain AND
			if ((q.alert_mask & ev_code) != 8'h00)
				d.alert = 1'b1;
		end

		// rf buffer fill; beyond capacity the byte is dropped
		if (rf_valid && !buf_full)
		begin
			d.mem[q.wptr[`RF_PTR_W-2:0]] = rf_byte;
			d.wptr = q.wptr + `RF_PTR_W'(1);
		end

		// output stage drains only while not holding
		if (q.out_valid && rf_out_ready)
			d.out_valid = 1'b0;
		if (!holding && !buf_empty && (!q.out_valid || rf_out_ready))
		begin
			d.out_valid = 1'b1;
			d.out_byte = q.mem[q.rptr[`RF_PTR_W-2:0]];
			d.rptr = q.rptr + `RF_PTR_W'(1);
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			q <= '0;
			q.st <= P_HDR;
			q.alert_mask <= `RST_ALERT_MASK;
			q.alert_mask_nv <= `RST_ALERT_MASK;
			q.traffic_hold <= `RST_TRAFFIC_HOLD;
			q.traffic_hold_nv <= `RST_TRAFFIC_HOLD;
			q.gain_mode <= `RST_GAIN_MODE;
			q.gain_mode_nv <= `RST_GAIN_MODE;
			q.legacy <= `RST_LEGACY;
			q.legacy_nv <= `RST_LEGACY;
			q.cmd_s1 <= 1'b1;
			q.cmd_s2 <= 1'b1;
			q.cmd_s3 <= 1'b1;
		end
		else
			q <= d;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign tx_valid = (q.st == P_RESP);
	assign tx_byte = q.resp[23:16];
	assign rf_out_valid = q.out_valid;
	assign rf_out_byte = q.out_byte;
	assign alert_line = q.alert;
	assign gain_mode = q.gain_mode;
	assign legacy_link_enable = q.legacy[0];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_mask_write_lands:
	assert property ((q.st == P_WVAL) && rx_valid && (q.addr == `ADDR_ALERT_MASK)
		|=> (q.alert_mask == $past(rx_byte)))
		else $error("mask write did not land at its address");

	a_alert_on_hit:
	assert property (ev_fire && ((q.alert_mask & ev_code) != 8'h00)
		|=> alert_line && (q.fault_code == $past(ev_code)))
		else $error("masked exception did not raise alert");

	a_zero_records_code:
	assert property (ev_fire && ((q.alert_mask & ev_code) == 8'h00) && !alert_line
		|=> !alert_line && (q.fault_code == $past(ev_code)))
		else $error("unmasked exception handled wrongly");

	a_read_clears_alert:
	assert property (fault_read && !ev_fire |=> !alert_line ##1 tx_valid)
		else $error("fault code read did not clear alert");

	a_hold_stalls_out:
	assert property (holding && !rf_out_valid && $stable(holding) |=> !rf_out_valid)
		else $error("rf data output while held");

	a_overflow_faults:
	assert property (rf_valid && buf_full |=> (q.fault_code == `CODE_RF_OVERFLOW))
		else $error("buffer overflow not reported");

	a_release_drains:
	assert property (!holding && !buf_empty && !rf_out_valid |=> rf_out_valid)
		else $error("buffered rf data not released");

	a_gain_in_range:
	assert property (gain_mode <= `GAIN_MODE_MAX)
		else $error("gain mode out of range");

	a_legacy_follows:
	assert property ((q.st == P_WVAL) && rx_valid && (q.addr == `ADDR_LEGACY)
		&& (rx_byte == `SWITCH_MAX) |=> legacy_link_enable)
		else $error("legacy enable did not follow write");

	a_read_answer:
	assert property ((q.st == P_RADDR) && rx_valid
		|=> tx_valid && (tx_byte == `FRAME_ACK))
		else $error("read frame not answered with ack");

	c_read_frame: cover property ((q.st == P_RESP) && tx_ready && (q.resp_left == 2'd0));
	c_alert_raised: cover property (!alert_line ##1 alert_line);
	c_overflow: cover property (rf_valid && buf_full);
	c_hold_release: cover property (holding ##1 !holding ##1 rf_out_valid);

endmodule

//--- testbench/host_model.sv
// host side model: sends framed commands and takes response bytes
`include "xcfg_defs.svh"
module host_model
(
	// clock
	input wire logic core_clk,
	// command bytes toward the block
	output logic rx_valid,
	output logic [7:0] rx_byte,
	// response handshake
	output logic tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle at time zero
	initial
	begin
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		tx_ready = 1'b0;
	end

	// response side stalls at random, so slow takers are exercised too
	always @(posedge core_clk)
	begin
		#1 tx_ready = ($urandom_range(0, 3) != 0);
	end

	// one frame, bytes on consecutive cycles; released line shows the inverse
	task automatic frame(input logic rd, input logic [7:0] a, input logic [7:0] v);
		logic [7:0] f [4];
		f = '{`FRAME_HEADER, `FRAME_SIZE, rd ? `FRAME_ESCAPE : a, rd ? a : v};
		foreach (f[i])
		begin
			@(posedge core_clk);
			#1;
			rx_valid = 1'b1;
			rx_byte = f[i];
		end
		@(posedge core_clk);
		#1;
		rx_valid = 1'b0;
		rx_byte = ~rx_byte;
	endtask
endmodule

//--- testbench/exception_mask_config_regs_bench.sv
// self-checking bench for the exception mask and configuration registers
`include "xcfg_defs.svh"
module exception_mask_config_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// signals and bookkeeping
	// ----------------------------------------
	logic core_clk, rst, rx_valid, tx_valid, tx_ready, cmd_n, exc_valid;
	logic rf_valid, rf_out_valid, rf_out_ready, alert_line, legacy_link_enable;
	logic [7:0] rx_byte, tx_byte, exc_code, rf_byte, rf_out_byte, gain_mode;
	logic [7:0] txq [$]; // expected response bytes
	logic [7:0] rfq [$]; // expected rf output bytes
	int errors = 0;
	int checked = 0;

	exception_mask_config_regs DUT (.core_clk(core_clk), .rst(rst), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
		.cmd_n(cmd_n), .exc_valid(exc_valid), .exc_code(exc_code), .rf_valid(rf_valid),
		.rf_byte(rf_byte), .rf_out_valid(rf_out_valid), .rf_out_byte(rf_out_byte),
		.rf_out_ready(rf_out_ready), .alert_line(alert_line), .gain_mode(gain_mode),
		.legacy_link_enable(legacy_link_enable));

	host_model host (.core_clk(core_clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
		.tx_ready(tx_ready));

	// 10 MHz clock
	always #50 core_clk = ~core_clk;

	// rf sink stalls at random
	always @(posedge core_clk)
	begin
		#1 rf_out_ready = ($urandom_range(0, 2) != 0);
	end

	// ----------------------------------------
	// checking tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
		checked++;
		if (seen !== want)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic complete_run();
		if (errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// watcher: each accepted output byte meets the oldest note
	always @(posedge core_clk)
	begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			check("tx_byte", tx_byte, txq.size() ? txq.pop_front() : 8'hxx);
		if (rf_out_valid === 1'b1 && rf_out_ready === 1'b1)
			check("rf_out_byte", rf_out_byte, rfq.size() ? rfq.pop_front() : 8'hxx);
	end

	// wait until all notes are taken, bounded so a hang ends the run
	task automatic drain();
		int n;
		n = 0;
		while ((txq.size() != 0 || rfq.size() != 0) && n < 300)
		begin
			@(posedge core_clk);
			n++;
		end
		if (txq.size() != 0 || rfq.size() != 0)
		begin
			errors++;
			complete_run();
		end
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	task automatic rd(input logic [7:0] a, input logic [7:0] v);
		txq.push_back(`FRAME_ACK);
		txq.push_back(a);
		txq.push_back(v);
		host.frame(1'b1, a, v);
		drain();
	endtask

	// writes have no answer; let the register settle
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		host.frame(1'b0, a, v);
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	// one-cycle exception event
	task automatic exc(input logic [7:0] code);
		exc_valid = 1'b1;
		exc_code = code;
		@(posedge core_clk);
		#1;
		exc_valid = 1'b0;
		exc_code = ~code;
	endtask

	// hold off for the command line synchroniser to follow
	task automatic cmd_line(input logic lvl);
		cmd_n = lvl;
		repeat (6) @(posedge core_clk);
		#1;
	endtask

	// rf bytes back to back, noting those that must come out
	task automatic rf_burst(input int cnt, input int keep);
		for (int n = 0; n < cnt; n++)
		begin
			rf_valid = 1'b1;
			rf_byte = 8'($urandom);
			if (n < keep)
				rfq.push_back(rf_byte);
			@(posedge core_clk);
			#1;
		end
		rf_valid = 1'b0;
		rf_byte = ~rf_byte;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		logic [7:0] masks [6];
		logic [7:0] codes [8];
		// 0x60 passes the crc group and the missing acknowledge together
		masks = '{8'h08, 8'h10, 8'h20, 8'h40, 8'h60, 8'hFF};
		codes = '{8'h08, 8'h09, 8'h13, 8'h20, 8'h40, 8'h42, 8'h43, 8'h44};
		void'($urandom(13967));
		core_clk = 1'b0;
		rst = 1'b1;
		cmd_n = 1'b1;
		exc_valid = 1'b0;
		exc_code = 8'h00;
		rf_valid = 1'b0;
		rf_byte = 8'h00;
		rf_out_ready = 1'b0;
		repeat (20) @(posedge core_clk);
		#1;
		rst = 1'b0;
		// reset values, then the non-volatile copy kept apart
		rd(`ADDR_ALERT_MASK, 8'h00);
		rd(`ADDR_TRAFFIC_HOLD, 8'h00);
		rd(`ADDR_GAIN_MODE, 8'h00);
		rd(`ADDR_LEGACY, 8'h00);
		wr(`ADDR_ALERT_MASK_NV, 8'h5A);
		rd(`ADDR_ALERT_MASK_NV, 8'h5A);
		rd(`ADDR_ALERT_MASK, 8'h00);
		rd(8'h00, 8'h00);
		// every gain mode, then the legacy switch both ways
		for (int g = 0; g < 4; g++)
		begin
			wr(`ADDR_GAIN_MODE, 8'(g));
			rd(`ADDR_GAIN_MODE, 8'(g));
			check("gain_mode", gain_mode, 8'(g));
		end
		for (int e = 1; e >= 0; e--)
		begin
			wr(`ADDR_LEGACY, 8'(e));
			check("legacy_link_enable", {7'h00, legacy_link_enable}, 8'(e));
		end
		// every example mask against every code; the read clears
		foreach (masks[m])
		begin
			wr(`ADDR_ALERT_MASK, masks[m]);
			foreach (codes[c])
			begin
				exc(codes[c]);
				check("alert_line", {7'h00, alert_line}, {7'h00, |(masks[m] & codes[c])});
				rd(`ADDR_FAULT_CODE, codes[c]);
				check("alert_line", {7'h00, alert_line}, 8'h00);
			end
		end
		// out of range gain is refused and reported, mask still all ones
		wr(`ADDR_GAIN_MODE, 8'h04);
		check("alert_line", {7'h00, alert_line}, 8'h01);
		rd(`ADDR_FAULT_CODE, `CODE_WRITE_FAILED);
		rd(`ADDR_GAIN_MODE, `GAIN_MODE_MAX);
		// non-volatile copies stay apart; oversized switch and fault code writes refused
		wr(`ADDR_TRAFFIC_HOLD_NV, `HOLD_ON);
		wr(`ADDR_GAIN_MODE_NV, 8'h02);
		wr(`ADDR_LEGACY_NV, 8'h02);
		check("alert_line", {7'h00, alert_line}, 8'h01);
		rd(`ADDR_FAULT_CODE, `CODE_WRITE_FAILED);
		wr(`ADDR_FAULT_CODE, 8'h00);
		rd(`ADDR_FAULT_CODE, `CODE_WRITE_FAILED);
		rd(`ADDR_TRAFFIC_HOLD_NV, `HOLD_ON);
		rd(`ADDR_GAIN_MODE_NV, 8'h02);
		rd(`ADDR_LEGACY_NV, 8'h00);
		rd(`ADDR_TRAFFIC_HOLD, 8'h00);
		// held traffic fills the buffer, one byte too many overflows
		wr(`ADDR_TRAFFIC_HOLD, `HOLD_ON);
		cmd_line(1'b0);
		rf_burst(`RF_BUF_DEPTH + 1, `RF_BUF_DEPTH);
		repeat (4) @(posedge core_clk);
		#1;
		check("rf_out_valid", {7'h00, rf_out_valid}, 8'h00);
		cmd_n = 1'b1;
		drain();
		rd(`ADDR_FAULT_CODE, `CODE_RF_OVERFLOW);
		// hold off: traffic flows even with the command line low
		wr(`ADDR_TRAFFIC_HOLD, 8'h00);
		cmd_line(1'b0);
		rf_burst(3, 3);
		drain();
		cmd_line(1'b1);
		// a second reset in mid-run returns the registers to their defaults
		rst = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		rst = 1'b0;
		check("gain_mode", gain_mode, `RST_GAIN_MODE);
		check("alert_line", {7'h00, alert_line}, 8'h00);
		rd(`ADDR_ALERT_MASK, `RST_ALERT_MASK);
		rd(`ADDR_LEGACY, `RST_LEGACY);
		complete_run();
	end
endmodule
